// File: hdl/pdr_pkg.sv
package pdr_pkg;

    // Register indices on the plain register port
    localparam logic [3:0] PDR_REG_CTRL   = 4'h0;
    localparam logic [3:0] PDR_REG_ROUTE  = 4'h1;
    localparam logic [3:0] PDR_REG_TXEN   = 4'h2;
    localparam logic [3:0] PDR_REG_SLOT0  = 4'h3;
    localparam logic [3:0] PDR_REG_SLOT3  = 4'h6;
    localparam logic [3:0] PDR_REG_STATUS = 4'h7;
    localparam logic [3:0] PDR_REG_PLAY   = 4'h8;

    localparam logic [15:0] PDR_CTRL_RST = 16'h0000;
    localparam logic [15:0] PDR_ZERO16   = 16'h0000;
    localparam logic [31:0] PDR_ZERO32   = 32'h0000_0000;

    // Channel word size codes
    localparam logic [1:0] PDR_CW_16 = 2'h0;
    localparam logic [1:0] PDR_CW_24 = 2'h1;
    localparam logic [5:0] PDR_BITS_16 = 6'h10;
    localparam logic [5:0] PDR_BITS_24 = 6'h18;
    localparam logic [5:0] PDR_BITS_32 = 6'h20;

    // Frame geometry
    localparam logic [8:0] PDR_POS_MAX    = 9'h1FF;
    localparam logic [4:0] PDR_I2S_CHANS  = 5'h02;
    localparam logic [4:0] PDR_TDM_CHANS  = 5'h10;
    localparam int         PDR_NTYPES     = 8;
    localparam int         PDR_SLOT_BITS  = 3;

    // Output data types
    localparam int PDR_T_VOLT = 0;
    localparam int PDR_T_CURR = 1;
    localparam int PDR_T_DSP  = 2;
    localparam int PDR_T_STAT = 7;

    localparam logic [5:0] PDR_TYPE_WIDTH [PDR_NTYPES] =
        '{6'h10, 6'h10, 6'h20, 6'h10, 6'h10, 6'h10, 6'h03, 6'h10};
    localparam logic [2:0] PDR_TYPE_SLOTS [PDR_NTYPES] =
        '{3'h2, 3'h2, 3'h4, 3'h2, 3'h2, 3'h2, 3'h1, 3'h2};
    localparam logic [PDR_NTYPES-1:0] PDR_TYPE_I2S = 8'h07;

    typedef struct packed {
        logic [5:0] rsvd;
        logic [1:0] chansz;
        logic       pad_highz;
        logic       interleave;
        logic       idle_highz;
        logic       mix_sum;
        logic       tdm;
        logic       tx_en;
        logic       byp_en;
        logic       rx_en;
    } pdr_ctrl_t;

    typedef struct packed {
        logic [15:0] voltage_sense;
        logic [15:0] current_sense;
        logic [31:0] dsp_monitor;
        logic [15:0] applied_attenuation;
        logic [15:0] battery_voltage;
        logic [15:0] high_rail_voltage;
        logic [2:0]  brownout_level;
        logic [13:0] raw_events;
    } pdr_src_t;

endpackage

// File: hdl/pdr_top.sv
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Contract
// - Playback disabled feeds zero code to the amplifier path.
// - Mono mixer passes one chosen channel or sums two chosen channels.
// - Two receive channels in I2S/left-justified, up to 16 in TDM.
// - Bypass enabled routes the selected channel to the bypass output.
// - Bypass disabled drives zero code into the bypass route.
// - Serial output transmits only while transmit enable is set.
// - I2S/left-justified transmit frames carry channels 0 and 1 only.
// - TDM transmit frame holds up to 64 eight-bit slots, 0 to 63.
// - I2S/left-justified offer only voltage, current and DSP monitor data.
// - Words wider than the channel lose their trailing low bits.
// - Each data type occupies a fixed number of slots by width.
// - In I2S, slot 0 means channel 0, slot 1 channel 1.
// - Multi-slot types start at their slot and fill following slots.
// - Unassigned or disabled slots are high-impedance or zero, by setting.
// - Interleave sends voltage and current on one channel in alternate frames.
// - Interleave padding beyond 16 bits is high-impedance or zero.
// - Interleave word drops LSB, shifts right, top bit marks current.
// - Current word goes first, matching voltage word in the next frame; the phase flips every frame, and the first frame after reset carries current.
// - Status bits 15 to 8 carry brownout and thermal warning events.
// - Status bits 7 to 2 carry foldback, headroom, overcurrent, power-up.
// - Raw event rise makes its status bit high for one frame only.
module pdr_top
    import pdr_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        bclk,
    input  wire logic        lrclk,
    input  wire logic        serial_data_in,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire pdr_src_t    src,
    output logic      [15:0] reg_rdata_q,
    output logic      [31:0] playback_sample_q,
    output logic      [31:0] bypass_sample_q,
    output logic             serial_data_out_q,
    output logic             serial_data_out_oe_q
);

    pdr_ctrl_t         ctrl_q;
    logic [15:0]       route_q;
    logic [7:0]        txen_q;
    logic [15:0]       slot_reg_q [4];
    logic [2:0]        sync1_q;
    logic [2:0]        sync2_q;
    logic              bclk_prev_q;
    logic              lr_last_q;
    logic              rise;
    logic              fall;
    logic              fsync;
    logic [8:0]        pos_q;
    logic [5:0]        cbit_q;
    logic [4:0]        cidx_q;
    logic [5:0]        cw;
    logic [4:0]        chan_limit;
    logic [31:0]       shift_q;
    logic [31:0]       rx_new;
    logic [31:0]       rx_word;
    logic [31:0]       mix_a_q;
    logic [31:0]       mix_b_q;
    logic [31:0]       byp_ch_q;
    logic [31:0]       mix_total;
    logic [13:0]       raw_prev_q;
    logic [13:0]       pend_q;
    logic [13:0]       raw_rise;
    logic [15:0]       status_q;
    logic              iv_phase_q;
    logic [31:0]       words [PDR_NTYPES];
    logic [5:0]        slot [PDR_NTYPES];
    logic              ilv_on;
    logic              tx_hit;
    logic              tx_bit;
    logic              tx_pad;

    // Register writes
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl_q  <= PDR_CTRL_RST;
            route_q <= PDR_ZERO16;
            txen_q  <= '0;
            for (int i = 0; i < 4; i++) begin
                slot_reg_q[i] <= PDR_ZERO16;
            end
        end else if (reg_wr) begin
            unique case (reg_addr)
                PDR_REG_CTRL:  ctrl_q  <= reg_wdata;
                PDR_REG_ROUTE: route_q <= reg_wdata;
                PDR_REG_TXEN:  txen_q  <= reg_wdata[7:0];
                default: begin
                    if (reg_addr >= PDR_REG_SLOT0 && reg_addr <= PDR_REG_SLOT3) begin
                        slot_reg_q[2'(reg_addr - PDR_REG_SLOT0)] <= reg_wdata;
                    end
                end
            endcase
        end
    end

    // Register reads, data one cycle later
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            reg_rdata_q <= PDR_ZERO16;
        end else if (reg_rd) begin
            unique case (reg_addr)
                PDR_REG_CTRL:   reg_rdata_q <= ctrl_q;
                PDR_REG_ROUTE:  reg_rdata_q <= route_q;
                PDR_REG_TXEN:   reg_rdata_q <= {8'h00, txen_q};
                PDR_REG_STATUS: reg_rdata_q <= status_q;
                PDR_REG_PLAY:   reg_rdata_q <= playback_sample_q[31:16];
                default: begin
                    if (reg_addr >= PDR_REG_SLOT0 && reg_addr <= PDR_REG_SLOT3) begin
                        reg_rdata_q <= slot_reg_q[2'(reg_addr - PDR_REG_SLOT0)];
                    end else begin
                        reg_rdata_q <= PDR_ZERO16;
                    end
                end
            endcase
        end
    end

    // Pin synchronisers and edge detection
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sync1_q     <= '0;
            sync2_q     <= '0;
            bclk_prev_q <= 1'b0;
            lr_last_q   <= 1'b0;
        end else begin
            sync1_q     <= {serial_data_in, lrclk, bclk};
            sync2_q     <= sync1_q;
            bclk_prev_q <= sync2_q[0];
            if (rise) begin
                lr_last_q <= sync2_q[1];
            end
        end
    end

    assign rise  = sync2_q[0] & ~bclk_prev_q;
    assign fall  = ~sync2_q[0] & bclk_prev_q;
    assign fsync = rise & sync2_q[1] & ~lr_last_q;

    always_comb begin
        unique case (ctrl_q.chansz)
            PDR_CW_16: cw = PDR_BITS_16;
            PDR_CW_24: cw = PDR_BITS_24;
            default:   cw = PDR_BITS_32;
        endcase
        chan_limit = ctrl_q.tdm ? PDR_TDM_CHANS : PDR_I2S_CHANS;
    end

    // Frame position counters: position of the next bit period
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pos_q  <= PDR_POS_MAX;
            cbit_q <= '0;
            cidx_q <= '0;
        end else if (fsync) begin
            pos_q  <= '0;
            cbit_q <= '0;
            cidx_q <= '0;
        end else if (rise) begin
            if (pos_q != PDR_POS_MAX) begin
                pos_q <= pos_q + 9'h001;
            end
            if (cbit_q == cw - 6'h01) begin
                cbit_q <= '0;
                if (cidx_q != 5'h1F) begin
                    cidx_q <= cidx_q + 5'h01;
                end
            end else begin
                cbit_q <= cbit_q + 6'h01;
            end
        end
    end

    // Receive channel capture
    assign rx_new  = {shift_q[30:0], sync2_q[2]};
    assign rx_word = rx_new << (PDR_BITS_32 - cw);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            shift_q  <= PDR_ZERO32;
            mix_a_q  <= PDR_ZERO32;
            mix_b_q  <= PDR_ZERO32;
            byp_ch_q <= PDR_ZERO32;
        end else if (rise && !fsync) begin
            shift_q <= rx_new;
            if (cbit_q == cw - 6'h01 && cidx_q < chan_limit) begin
                if (cidx_q[3:0] == route_q[3:0]) begin
                    mix_a_q <= rx_word;
                end
                if (cidx_q[3:0] == route_q[7:4]) begin
                    mix_b_q <= rx_word;
                end
                if (cidx_q[3:0] == route_q[11:8]) begin
                    byp_ch_q <= rx_word;
                end
            end
        end
    end

    assign mix_total = mix_a_q + mix_b_q;

    // Playback and bypass sample outputs, updated at frame start
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            playback_sample_q <= PDR_ZERO32;
            bypass_sample_q   <= PDR_ZERO32;
        end else if (fsync) begin
            if (!ctrl_q.rx_en) begin
                playback_sample_q <= PDR_ZERO32;
            end else begin
                playback_sample_q <= ctrl_q.mix_sum ? mix_total : mix_a_q;
            end
            bypass_sample_q <= ctrl_q.byp_en ? byp_ch_q : PDR_ZERO32;
        end
    end

    // Status events: set wins over the frame-start hand-off
    assign raw_rise = src.raw_events & ~raw_prev_q;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            raw_prev_q <= '0;
            pend_q     <= '0;
            status_q   <= PDR_ZERO16;
        end else begin
            raw_prev_q <= src.raw_events;
            if (fsync) begin
                status_q <= {pend_q, 2'b00};
                pend_q   <= raw_rise;
            end else begin
                pend_q <= pend_q | raw_rise;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            iv_phase_q <= 1'b0;
        end else if (fsync) begin
            iv_phase_q <= ~iv_phase_q;
        end
    end

    // Transmit data table, MSB aligned
    always_comb begin
        words[0] = {src.voltage_sense, 16'h0000};
        words[1] = {src.current_sense, 16'h0000};
        words[2] = src.dsp_monitor;
        words[3] = {src.applied_attenuation, 16'h0000};
        words[4] = {src.battery_voltage, 16'h0000};
        words[5] = {src.high_rail_voltage, 16'h0000};
        words[6] = {src.brownout_level, 29'h0000_0000};
        words[7] = {status_q, 16'h0000};
        for (int t = 0; t < PDR_NTYPES; t++) begin
            slot[t] = t[0] ? slot_reg_q[t/2][13:8] : slot_reg_q[t/2][5:0];
        end
    end

    assign ilv_on = ctrl_q.interleave && txen_q[PDR_T_VOLT] && txen_q[PDR_T_CURR]
                    && slot[PDR_T_VOLT] == slot[PDR_T_CURR];

    always_comb begin
        logic [8:0]  base;
        logic [9:0]  span_end;
        logic [8:0]  idx;
        logic        hit_t;
        logic [31:0] w;
        logic [5:0]  width;
        base     = '0;
        span_end = '0;
        idx      = '0;
        hit_t    = 1'b0;
        w        = '0;
        width    = '0;
        tx_hit = 1'b0;
        tx_bit = 1'b0;
        tx_pad = 1'b0;
        for (int t = 0; t < PDR_NTYPES; t++) begin
            base     = {slot[t], 3'b000};
            span_end = {1'b0, base} + {4'h0, PDR_TYPE_SLOTS[t], 3'b000};
            w        = words[t];
            width    = PDR_TYPE_WIDTH[t];
            if (ctrl_q.tdm) begin
                hit_t = {1'b0, pos_q} < span_end && pos_q >= base;
                idx   = pos_q - base;
            end else begin
                hit_t = PDR_TYPE_I2S[t] && cidx_q < PDR_I2S_CHANS
                        && slot[t] == {1'b0, cidx_q};
                idx   = {3'b000, cbit_q};
            end
            if (ilv_on && t == PDR_T_VOLT) begin
                w     = {iv_phase_q, iv_phase_q ? src.current_sense[15:1]
                                                : src.voltage_sense[15:1],
                         16'h0000};
                width = PDR_BITS_16;
            end
            if (txen_q[t] && hit_t && !(ilv_on && t == PDR_T_CURR)) begin
                tx_hit = 1'b1;
                if (idx < {3'b000, width}) begin
                    tx_bit = w[5'(31 - idx)];
                end else begin
                    tx_pad = ilv_on && t == PDR_T_VOLT && ctrl_q.pad_highz;
                end
            end
        end
    end

    // Serial output changes on the falling bit-clock edge
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            serial_data_out_q    <= 1'b0;
            serial_data_out_oe_q <= 1'b0;
        end else if (fall) begin
            if (!ctrl_q.tx_en) begin
                serial_data_out_q    <= 1'b0;
                serial_data_out_oe_q <= 1'b0;
            end else if (!tx_hit) begin
                serial_data_out_q    <= 1'b0;
                serial_data_out_oe_q <= !ctrl_q.idle_highz;
            end else begin
                serial_data_out_q    <= tx_bit;
                serial_data_out_oe_q <= !tx_pad;
            end
        end
    end

    sequence s_frame_start;
        fsync;
    endsequence

    sequence s_idle_fall;
        fall && ctrl_q.tx_en && !tx_hit && !ctrl_q.idle_highz;
    endsequence

    a_rx_off_zero: assert property (@(posedge ref_clk) disable iff (reset)
        s_frame_start and !ctrl_q.rx_en |=> playback_sample_q == PDR_ZERO32)
        else $error("playback not zero while disabled");
    a_mix_sum_out: assert property (@(posedge ref_clk) disable iff (reset)
        s_frame_start and ctrl_q.rx_en and ctrl_q.mix_sum
        |=> playback_sample_q == $past(mix_a_q) + $past(mix_b_q))
        else $error("mixer sum wrong");
    a_bypass_pass: assert property (@(posedge ref_clk) disable iff (reset)
        s_frame_start and ctrl_q.byp_en |=> bypass_sample_q == $past(byp_ch_q))
        else $error("bypass sample wrong");
    a_bypass_zero: assert property (@(posedge ref_clk) disable iff (reset)
        s_frame_start and !ctrl_q.byp_en |=> bypass_sample_q == PDR_ZERO32)
        else $error("bypass not zero while disabled");
    a_tx_off_float: assert property (@(posedge ref_clk) disable iff (reset)
        fall && !ctrl_q.tx_en |=> !serial_data_out_oe_q)
        else $error("output driven while transmit disabled");
    a_idle_slot_zero: assert property (@(posedge ref_clk) disable iff (reset)
        s_idle_fall |=> serial_data_out_oe_q && !serial_data_out_q)
        else $error("idle slot not zero");
    a_status_one_frame: assert property (@(posedge ref_clk) disable iff (reset)
        s_frame_start |=> status_q == {$past(pend_q), 2'b00} && pend_q == $past(raw_rise))
        else $error("status hand-off wrong");
    a_iv_alternate: assert property (@(posedge ref_clk) disable iff (reset)
        s_frame_start ##1 (!fsync)[*2] |-> iv_phase_q != $past(iv_phase_q, 3))
        else $error("interleave phase did not toggle");
    a_slot_advance: assert property (@(posedge ref_clk) disable iff (reset)
        rise && !fsync && pos_q != PDR_POS_MAX |=> pos_q == $past(pos_q) + 9'h001)
        else $error("bit position did not advance");

endmodule

// File: testbench/pdr_host_model.sv
`timescale 1ns/1ps
module pdr_host_model (
    output logic     bclk,
    output logic     lrclk,
    output logic     din,
    input  wire logic dout,
    input  wire logic dout_oe
);
    localparam int HALF = 160;

    initial begin
        bclk = 1'b0;
        lrclk = 1'b0;
        din = 1'b0;
    end

    // Sync rise, then 64 positions MSB first; bit clock idles low between frames
    task automatic run_frame(input logic [63:0] tx, output logic [63:0] rx,
                             output logic [63:0] oe);
        #7;
        for (int p = -1; p < 64; p++) begin
            lrclk = (p < 31);
            if (p < 0) begin
                din = ~din;
            end else begin
                din = tx[63-p];
            end
            #HALF bclk = 1'b1;
            #HALF bclk = 0;
            // Sampled before the output moves; a released line reads inverted
            if (p >= 0) begin
                rx[63-p] = dout_oe ? dout : ~dout;
                oe[63-p] = dout_oe;
            end
        end
        din = ~din;
    endtask
endmodule

// File: testbench/pdr_top_test.sv
`timescale 1ns/1ps
module pdr_top_test;
    import pdr_pkg::*;
    logic        ref_clk;
    logic        reset;
    logic        bclk;
    logic        lrclk;
    logic        din;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    pdr_src_t    src;
    logic [15:0] rdata;
    logic [31:0] play;
    logic [31:0] byp;
    logic        dout;
    logic        dout_oe;
    logic [63:0] rx;
    logic [63:0] oe;
    logic [63:0] rx2;
    logic [63:0] m;
    logic [15:0] v;
    int          fail_count = 0;
    int          checks_done = 0;
    int          cycles = 0;

    pdr_top u_dut (.ref_clk(ref_clk), .reset(reset), .bclk(bclk), .lrclk(lrclk),
        .serial_data_in(din), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .src(src), .reg_rdata_q(rdata),
        .playback_sample_q(play), .bypass_sample_q(byp), .serial_data_out_q(dout),
        .serial_data_out_oe_q(dout_oe));

    pdr_host_model u_host (.bclk(bclk), .lrclk(lrclk), .din(din), .dout(dout),
        .dout_oe(dout_oe));

    initial ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 50000) begin
            fail_count++;
            results();
        end
    end

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        if (fail_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Two identical frames; rx and oe hold the second
    task automatic frames(input logic [63:0] tx);
        u_host.run_frame(tx, rx, oe);
        u_host.run_frame(tx, rx, oe);
        repeat (4) @(posedge ref_clk);
    endtask

    function automatic logic [31:0] tv(input int t);
        case (t)
            0: tv = {src.voltage_sense, 16'h0000};
            1: tv = {src.current_sense, 16'h0000};
            2: tv = src.dsp_monitor;
            3: tv = {src.applied_attenuation, 16'h0000};
            4: tv = {src.battery_voltage, 16'h0000};
            5: tv = {src.high_rail_voltage, 16'h0000};
            6: tv = {src.brownout_level, 29'h0};
            default: tv = 32'h0;
        endcase
    endfunction

    initial begin
        reset = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        src = '{16'hA5C3, 16'h5A3C, 32'h1234_5678, 16'hC0DE, 16'hBA77, 16'h7E11, 3'h5, 14'h0};
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        rd(PDR_REG_CTRL, v);
        check("ctrl reset", v, 16'h0000);
        rd(4'hF, v);
        check("unmapped", v, 16'h0000);
        frames(64'h0);
        check("oe tx off", oe, 64'h0);
        // Two channels, 32-bit words
        wr(4'h3, 16'h0000);
        wr(4'h4, 16'h0001);
        wr(PDR_REG_TXEN, 16'h0005);
        wr(PDR_REG_CTRL, 16'h0204);
        frames(64'h0);
        check("i2s data", rx, {16'hA5C3, 16'h0, 32'h1234_5678});
        check("i2s oe", oe, ~64'h0);
        wr(PDR_REG_CTRL, 16'h0004);
        frames(64'h0);
        check("i2s cw16", rx[63:32], {16'hA5C3, 16'h1234});
        wr(PDR_REG_CTRL, 16'h0104);
        frames(64'h0);
        check("i2s cw24", rx[63:16], {16'hA5C3, 8'h00, 24'h12_3456});
        // Attenuation is not offered on a two-channel frame
        wr(PDR_REG_TXEN, 16'h000C);
        wr(PDR_REG_CTRL, 16'h0004);
        frames(64'h0);
        check("i2s no atten", rx[63:32], {16'h0000, 16'h1234});
        // Each type alone at slot 2
        for (int t = 0; t < 8; t++) begin
            wr(4'(3 + t / 2), (t % 2) ? 16'h0200 : 16'h0002);
            wr(PDR_REG_TXEN, 16'(1 << t));
            wr(PDR_REG_CTRL, (t % 2) ? 16'h023C : 16'h021C);
            frames(64'h0);
            m = (~64'h0 << (64 - 8 * PDR_TYPE_SLOTS[t])) >> 16;
            if (t % 2 == 0) m = ~64'h0;
            check("tdm word", rx & m, {16'h0, tv(t), 16'h0} & m);
            check("tdm oe", oe, m);
        end
        // Status events, one per raw bit
        wr(4'h6, 16'h0000);
        wr(PDR_REG_TXEN, 16'h0080);
        wr(PDR_REG_CTRL, 16'h002C);
        for (int i = 0; i < 14; i++) begin
            @(posedge ref_clk);
            src.raw_events <= 14'(1 << i);
            u_host.run_frame(64'h0, rx, oe);
            check("status on", rx[63:48], 16'(16'h0004 << i));
            rd(PDR_REG_STATUS, v);
            check("status reg", v, 16'(16'h0004 << i));
            u_host.run_frame(64'h0, rx, oe);
            check("status off", rx[63:48], 16'h0000);
            @(posedge ref_clk);
            src.raw_events <= 14'h0;
        end
        // Interleaved sense on channel 0
        wr(4'h3, 16'h0000);
        wr(PDR_REG_TXEN, 16'h0003);
        wr(PDR_REG_CTRL, 16'h02C4);
        frames(64'h0);
        rx2 = rx;
        u_host.run_frame(64'h0, rx, oe);
        // Phase is read from the marker bit; contents must match the other type
        check("iv pair", {rx2[63:48], rx[63:48]},
              rx2[63] ? {16'hAD1E, 16'h52E1} : {16'h52E1, 16'hAD1E});
        check("iv pad", oe, {16'hFFFF, 16'h0, 32'hFFFF_FFFF});
        // Receive mixing and bypass
        wr(PDR_REG_ROUTE, 16'h0110);
        wr(PDR_REG_CTRL, 16'h0213);
        frames({32'h1000_0001, 32'h2000_0002});
        check("mix sum", play, 32'h3000_0003);
        check("bypass", byp, 32'h2000_0002);
        rd(PDR_REG_PLAY, v);
        check("play reg", v, 16'h3000);
        wr(PDR_REG_CTRL, 16'h0203);
        frames({32'h1000_0001, 32'h2000_0002});
        check("mix one", play, 32'h1000_0001);
        wr(PDR_REG_ROUTE, 16'h0303);
        rd(PDR_REG_ROUTE, v);
        check("route rd", v, 16'h0303);
        wr(PDR_REG_CTRL, 16'h000B);
        frames(64'h1111_2222_3333_4444);
        check("tdm ch3", play, 32'h4444_0000);
        check("tdm byp", byp, 32'h4444_0000);
        wr(PDR_REG_CTRL, 16'h0008);
        frames(64'h1111_2222_3333_4444);
        check("rx off", play, 32'h0);
        check("byp off", byp, 32'h0);
        results();
    end
endmodule
